// ===== verilog/plc_bit_logic_consts.svh
// constants of the bit-logic and interpolation unit: offsets, fields, resets, limits
// assumes byte addresses on a 32-bit classic wishbone slave
`ifndef PLC_BIT_LOGIC_CONSTS_SVH
`define PLC_BIT_LOGIC_CONSTS_SVH

// ==========================================================
// register byte offsets (word aligned)
`define OFS_CTRL        13'h0000
`define OFS_OPERAND_A   13'h0004
`define OFS_OPERAND_B   13'h0008
`define OFS_BIT_INDEX   13'h000c
`define OFS_LOGIC_RES   13'h0010
`define OFS_INSERT_DEST 13'h0014
`define OFS_SOURCE_BASE 13'h0018
`define OFS_SOURCE_CNT  13'h001c
`define OFS_X_BASE      13'h0020
`define OFS_Y_BASE      13'h0024
`define OFS_TABLE_LEN   13'h0028
`define OFS_DEST_BASE   13'h002c
`define OFS_STATUS      13'h0030
`define OFS_IRQ_STATUS  13'h0034
`define OFS_IRQ_MASK    13'h0038
// address bit that selects the word memory window
`define MEM_WINDOW_BIT  12

// ==========================================================
// control register fields
`define CTRL_INTERP_EN  0
`define CTRL_XOR_EN     1
`define CTRL_EQUIV_EN   2
`define CTRL_EXTRACT_EN 3
`define CTRL_INSERT_EN  4
`define CTRL_PULSE      5
`define CTRL_WIDE       6
`define CTRL_XY_SEL     7
`define CTRL_IDLE_CLR   8
`define CTRL_INSERT_BIT 9
`define CTRL_WIDTH      10

// ==========================================================
// event bits, shared by irq status and irq mask
`define EV_DONE         0
`define EV_SPAN         1
`define EV_ZERO         2
`define EV_EXTRACT_ERR  3
`define EV_INSERT_ERR   4
`define EV_WIDTH        5

// ==========================================================
// reset values
`define CTRL_RESET      10'h000
`define WORD_RESET      32'h00000000
`define IRQ_RESET       5'h00

// ==========================================================
// operand limits
`define SRC_CNT_MIN     7'h01
`define SRC_CNT_MAX     7'h40
`define TBL_LEN_MIN     8'h02
`define IDX_LIMIT_16    6'h10
`define IDX_LIMIT_32    6'h20
`define MEM_AW          10
`define MEM_DW          16

`endif

// ===== verilog/plc_bit_logic_pkg.sv
// types shared by the unit and its word memory
// assumes plc_bit_logic_consts.svh for widths
`include "plc_bit_logic_consts.svh"

package plc_bit_logic_pkg;
  typedef logic [31:0]           bus_word_t;
  typedef logic [12:0]           bus_addr_t;
  typedef logic [`MEM_AW-1:0]    mem_addr_t;
  typedef logic [`MEM_DW-1:0]    mem_word_t;
  typedef enum {
    S_IDLE, S_SRC, S_T0, S_TLO, S_THI, S_OLO, S_OHI, S_MUL, S_DIV, S_WR, S_NEXT
  } interp_state_e;
endpackage

// ===== verilog/word_ram.sv
// single-port word memory that holds sources, tables and results
// assumes one user at a time; read data is registered, one cycle of latency
`timescale 1ns/1ns
`include "plc_bit_logic_consts.svh"

module word_ram (
  input  wire logic                       clk,   // system clock
  input  wire plc_bit_logic_pkg::mem_addr_t addr,  // word address
  input  wire logic                       we,    // write strobe
  input  wire plc_bit_logic_pkg::mem_word_t wdata, // write data
  output      plc_bit_logic_pkg::mem_word_t rdata  // registered read data
);
  import plc_bit_logic_pkg::*;

  mem_word_t mem [0:(1<<`MEM_AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// ===== verilog/plc_bit_logic_interp_unit.sv
// bit logic, bit extract/insert and multi-segment table interpolation unit
// assumes a classic wishbone master on the same clock and synchronous reset
//
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "plc_bit_logic_consts.svh"

module plc_bit_logic_interp_unit (
  input  wire logic                         clk,               // 250 MHz clock
  input  wire logic                         rst,               // sync reset, high
  input  wire logic                         wb_cyc_i,          // bus cycle
  input  wire logic                         wb_stb_i,          // bus strobe
  input  wire logic                         wb_we_i,           // write enable
  input  wire plc_bit_logic_pkg::bus_addr_t wb_adr_i,          // byte address
  input  wire logic [3:0]                   wb_sel_i,          // byte lanes
  input  wire plc_bit_logic_pkg::bus_word_t wb_dat_i,          // write data
  output      plc_bit_logic_pkg::bus_word_t wb_dat_o,          // read data
  output      logic                         wb_ack_o,          // acknowledge
  output      logic                         irq,               // level interrupt
  output      logic                         extracted_bit_out, // extract result
  output      logic                         zero_flag,         // logic result zero
  output      logic                         out_of_span_flag,  // interp miss
  output      logic                         extract_err,       // bad extract index
  output      logic                         insert_err         // bad insert index
);
  import plc_bit_logic_pkg::*;

  // ==========================================================
  // state
  logic [`CTRL_WIDTH-1:0] ctrl, next_ctrl;
  bus_word_t              operand_a, next_operand_a;
  bus_word_t              operand_b, next_operand_b;
  logic [5:0]             bit_index, next_bit_index;
  bus_word_t              logic_res, next_logic_res;
  bus_word_t              insert_dest, next_insert_dest;
  mem_addr_t              source_base, next_source_base;
  logic [6:0]             source_cnt, next_source_cnt;
  mem_addr_t              x_base, next_x_base;
  mem_addr_t              y_base, next_y_base;
  logic [7:0]             table_length, next_table_length;
  mem_addr_t              dest_base, next_dest_base;
  logic [`EV_WIDTH-1:0]   irq_status, next_irq_status;
  logic [`EV_WIDTH-1:0]   irq_mask, next_irq_mask;
  logic [4:0]             en_prev, next_en_prev;
  logic                   mem_pend, next_mem_pend;
  bus_word_t              next_wb_dat_o;
  logic                   next_wb_ack_o, next_irq, next_extracted_bit_out;
  logic                   next_zero_flag, next_extract_err, next_insert_err;

  interp_state_e          state, next_state;
  logic [6:0]             src_i, next_src_i;
  logic [7:0]             seg_n, next_seg_n;
  logic signed [15:0]     val, next_val;
  logic signed [15:0]     in_lo, next_in_lo;
  logic signed [15:0]     in_hi, next_in_hi;
  logic signed [15:0]     out_lo, next_out_lo;
  logic signed [15:0]     out_hi, next_out_hi;
  logic signed [33:0]     num, next_num;
  logic signed [16:0]     den, next_den;
  logic signed [15:0]     res, next_res;
  logic                   next_out_of_span_flag;

  // ==========================================================
  // shared combinational terms
  logic [4:0]  en_now, trig;
  logic        req, is_mem, bus_grant, mem_go, start, params_ok;
  logic        ev_done, ev_span;
  mem_addr_t   ram_addr, fsm_addr;
  logic        ram_we;
  mem_word_t   ram_wdata, ram_rdata;
  mem_addr_t   in_base, out_base;
  logic signed [15:0] rd_s;
  logic signed [33:0] quot;

  assign en_now = ctrl[`CTRL_INSERT_EN:`CTRL_INTERP_EN];
  // pulse variant fires on the rising edge only
  assign trig = ctrl[`CTRL_PULSE] ? (en_now & ~en_prev) : en_now;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign is_mem = wb_adr_i[`MEM_WINDOW_BIT];
  assign params_ok = (source_cnt >= `SRC_CNT_MIN) && (source_cnt <= `SRC_CNT_MAX)
                     && (table_length >= `TBL_LEN_MIN);
  assign start = (state == S_IDLE) && trig[`CTRL_INTERP_EN] && params_ok;
  // the bus reaches the memory only between runs, so a run never sees torn tables
  assign bus_grant = (state == S_IDLE) && !start;
  assign mem_go = req && is_mem && !mem_pend && bus_grant;
  assign in_base = ctrl[`CTRL_XY_SEL] ? y_base : x_base;
  assign out_base = ctrl[`CTRL_XY_SEL] ? x_base : y_base;
  assign rd_s = $signed(ram_rdata);
  // signed divide in the language truncates toward zero
  assign quot = (den == 17'sh00000) ? 34'sh000000000 : (num / den);

  assign ram_addr = bus_grant ? wb_adr_i[`MEM_AW+1:2] : fsm_addr;
  assign ram_we = bus_grant ? (mem_go && wb_we_i) : (state == S_WR);
  assign ram_wdata = bus_grant ? wb_dat_i[`MEM_DW-1:0] : res;

  word_ram u_ram (
    .clk   (clk),
    .addr  (ram_addr),
    .we    (ram_we),
    .wdata (ram_wdata),
    .rdata (ram_rdata)
  );

  function automatic bus_word_t merge(input bus_word_t old, input bus_word_t nw,
                                      input logic [3:0] sel);
    bus_word_t r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // interpolation sequencer
  always_comb begin
    next_state = state;
    next_src_i = src_i;
    next_seg_n = seg_n;
    next_val = val;
    next_in_lo = in_lo;
    next_in_hi = in_hi;
    next_out_lo = out_lo;
    next_out_hi = out_hi;
    next_num = num;
    next_den = den;
    next_res = res;
    next_out_of_span_flag = out_of_span_flag;
    fsm_addr = source_base + mem_addr_t'(src_i);
    ev_done = 1'b0;
    ev_span = 1'b0;
    case (state)
      S_IDLE: begin
        if (start) begin
          next_src_i = 7'h00;
          next_out_of_span_flag = 1'b0;
          next_state = S_SRC;
        end
      end
      S_SRC: begin
        next_state = S_T0;
      end
      S_T0: begin
        next_val = rd_s;
        next_seg_n = 8'h00;
        fsm_addr = in_base;
        next_state = S_TLO;
      end
      S_TLO: begin
        next_in_lo = rd_s;
        fsm_addr = in_base + mem_addr_t'(seg_n + 8'h01);
        next_state = S_THI;
      end
      S_THI: begin
        next_in_hi = rd_s;
        // either orientation brackets, so descending input tables (x, or y with CTRL_XY_SEL) work too
        if (((val >= in_lo) && (val <= rd_s)) || ((val <= in_lo) && (val >= rd_s))) begin
          fsm_addr = out_base + mem_addr_t'(seg_n);
          next_state = S_OLO;
        end else if (seg_n + 8'h02 >= table_length) begin
          next_out_of_span_flag = 1'b1;
          ev_span = 1'b1;
          next_state = S_NEXT;
        end else begin
          next_in_lo = rd_s;
          next_seg_n = seg_n + 8'h01;
          fsm_addr = in_base + mem_addr_t'(seg_n + 8'h02);
        end
      end
      S_OLO: begin
        next_out_lo = rd_s;
        fsm_addr = out_base + mem_addr_t'(seg_n + 8'h01);
        next_state = S_OHI;
      end
      S_OHI: begin
        next_out_hi = rd_s;
        next_state = S_MUL;
      end
      S_MUL: begin
        next_num = (34'(val) - 34'(in_lo)) * (34'(out_hi) - 34'(out_lo));
        next_den = {in_hi[15], in_hi} - {in_lo[15], in_lo};
        next_state = S_DIV;
      end
      S_DIV: begin
        next_res = out_lo + quot[15:0];
        next_state = S_WR;
      end
      S_WR: begin
        fsm_addr = dest_base + mem_addr_t'(src_i);
        next_state = S_NEXT;
      end
      S_NEXT: begin
        if (src_i + 7'h01 >= source_cnt) begin
          ev_done = 1'b1;
          next_state = S_IDLE;
        end else begin
          next_src_i = src_i + 7'h01;
          next_state = S_SRC;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= S_IDLE;
      src_i <= 7'h00;
      seg_n <= 8'h00;
      val <= 16'sh0000;
      in_lo <= 16'sh0000;
      in_hi <= 16'sh0000;
      out_lo <= 16'sh0000;
      out_hi <= 16'sh0000;
      num <= 34'sh000000000;
      den <= 17'sh00000;
      res <= 16'sh0000;
      out_of_span_flag <= 1'b0;
    end else begin
      state <= next_state;
      src_i <= next_src_i;
      seg_n <= next_seg_n;
      val <= next_val;
      in_lo <= next_in_lo;
      in_hi <= next_in_hi;
      out_lo <= next_out_lo;
      out_hi <= next_out_hi;
      num <= next_num;
      den <= next_den;
      res <= next_res;
      out_of_span_flag <= next_out_of_span_flag;
    end
  end

  // ==========================================================
  // bus slave, bit logic and interrupts
  always_comb begin
    bus_word_t          rd;
    bus_word_t          lres;
    logic               idx_ok;
    logic [`EV_WIDTH-1:0] ev, clr;
    rd = 32'h00000000;
    lres = 32'h00000000;
    idx_ok = 1'b0;
    ev = '0;
    clr = '0;
    next_ctrl = ctrl;
    next_operand_a = operand_a;
    next_operand_b = operand_b;
    next_bit_index = bit_index;
    next_logic_res = logic_res;
    next_insert_dest = insert_dest;
    next_source_base = source_base;
    next_source_cnt = source_cnt;
    next_x_base = x_base;
    next_y_base = y_base;
    next_table_length = table_length;
    next_dest_base = dest_base;
    next_irq_mask = irq_mask;
    next_en_prev = en_now;
    next_mem_pend = mem_pend;
    next_wb_dat_o = wb_dat_o;
    next_wb_ack_o = 1'b0;
    next_extracted_bit_out = extracted_bit_out;
    next_zero_flag = zero_flag;
    next_extract_err = extract_err;
    next_insert_err = insert_err;

    idx_ok = bit_index < (ctrl[`CTRL_WIDE] ? `IDX_LIMIT_32 : `IDX_LIMIT_16);
    if (trig[`CTRL_XOR_EN] || trig[`CTRL_EQUIV_EN]) begin
      lres = operand_a ^ operand_b;
      if (!trig[`CTRL_XOR_EN]) begin
        lres = ~lres;
      end
      if (!ctrl[`CTRL_WIDE]) begin
        lres = {16'h0000, lres[15:0]};
      end
      next_logic_res = lres;
      next_zero_flag = (lres == 32'h00000000);
      ev[`EV_ZERO] = (lres == 32'h00000000);
    end
    if (trig[`CTRL_EXTRACT_EN]) begin
      next_extract_err = !idx_ok;
      ev[`EV_EXTRACT_ERR] = !idx_ok;
      if (idx_ok) begin
        next_extracted_bit_out = operand_a[bit_index[4:0]];
      end
    end else if (!en_now[`CTRL_EXTRACT_EN] && ctrl[`CTRL_IDLE_CLR]) begin
      next_extracted_bit_out = 1'b0;
    end
    if (trig[`CTRL_INSERT_EN]) begin
      next_insert_err = !idx_ok;
      ev[`EV_INSERT_ERR] = !idx_ok;
      if (idx_ok) begin
        next_insert_dest[bit_index[4:0]] = ctrl[`CTRL_INSERT_BIT];
      end
    end
    ev[`EV_DONE] = ev_done;
    ev[`EV_SPAN] = ev_span;

    if (mem_pend) begin
      next_mem_pend = 1'b0;
      next_wb_ack_o = 1'b1;
      next_wb_dat_o = {16'h0000, ram_rdata};
    end else if (mem_go) begin
      next_mem_pend = !wb_we_i;
      next_wb_ack_o = wb_we_i;
    end else if (req && !is_mem) begin
      next_wb_ack_o = 1'b1;
      case ({wb_adr_i[12:2], 2'b00})
        `OFS_CTRL:        rd = {22'h0, ctrl};
        `OFS_OPERAND_A:   rd = operand_a;
        `OFS_OPERAND_B:   rd = operand_b;
        `OFS_BIT_INDEX:   rd = {26'h0, bit_index};
        `OFS_LOGIC_RES:   rd = logic_res;
        `OFS_INSERT_DEST: rd = insert_dest;
        `OFS_SOURCE_BASE: rd = {22'h0, source_base};
        `OFS_SOURCE_CNT:  rd = {25'h0, source_cnt};
        `OFS_X_BASE:      rd = {22'h0, x_base};
        `OFS_Y_BASE:      rd = {22'h0, y_base};
        `OFS_TABLE_LEN:   rd = {24'h0, table_length};
        `OFS_DEST_BASE:   rd = {22'h0, dest_base};
        `OFS_STATUS:      rd = {26'h0, state != S_IDLE, insert_err, extract_err,
                                zero_flag, out_of_span_flag, extracted_bit_out};
        `OFS_IRQ_STATUS:  rd = {27'h0, irq_status};
        `OFS_IRQ_MASK:    rd = {27'h0, irq_mask};
        default:          rd = 32'h00000000;
      endcase
      next_wb_dat_o = rd;
      if (wb_we_i) begin
        case ({wb_adr_i[12:2], 2'b00})
          `OFS_CTRL:        next_ctrl = 10'(merge({22'h0, ctrl}, wb_dat_i, wb_sel_i));
          `OFS_OPERAND_A:   next_operand_a = merge(operand_a, wb_dat_i, wb_sel_i);
          `OFS_OPERAND_B:   next_operand_b = merge(operand_b, wb_dat_i, wb_sel_i);
          `OFS_BIT_INDEX:   next_bit_index = 6'(merge({26'h0, bit_index}, wb_dat_i, wb_sel_i));
          `OFS_INSERT_DEST: next_insert_dest = merge(next_insert_dest, wb_dat_i, wb_sel_i);
          `OFS_SOURCE_BASE: next_source_base = 10'(merge({22'h0, source_base}, wb_dat_i,
                                                     wb_sel_i));
          `OFS_SOURCE_CNT:  next_source_cnt = 7'(merge({25'h0, source_cnt}, wb_dat_i, wb_sel_i));
          `OFS_X_BASE:      next_x_base = 10'(merge({22'h0, x_base}, wb_dat_i, wb_sel_i));
          `OFS_Y_BASE:      next_y_base = 10'(merge({22'h0, y_base}, wb_dat_i, wb_sel_i));
          `OFS_TABLE_LEN:   next_table_length = 8'(merge({24'h0, table_length}, wb_dat_i,
                                                      wb_sel_i));
          `OFS_DEST_BASE:   next_dest_base = 10'(merge({22'h0, dest_base}, wb_dat_i, wb_sel_i));
          `OFS_IRQ_STATUS:  clr = wb_sel_i[0] ? wb_dat_i[`EV_WIDTH-1:0] : '0;
          `OFS_IRQ_MASK:    next_irq_mask = wb_sel_i[0] ? wb_dat_i[`EV_WIDTH-1:0] : irq_mask;
          default:          next_ctrl = ctrl;
        endcase
      end
    end
    // a fresh event beats a write-one-to-clear in the same cycle
    next_irq_status = (irq_status & ~clr) | ev;
    next_irq = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= `CTRL_RESET;
      operand_a <= `WORD_RESET;
      operand_b <= `WORD_RESET;
      bit_index <= 6'h00;
      logic_res <= `WORD_RESET;
      insert_dest <= `WORD_RESET;
      source_base <= 10'h000;
      source_cnt <= 7'h00;
      x_base <= 10'h000;
      y_base <= 10'h000;
      table_length <= 8'h00;
      dest_base <= 10'h000;
      irq_status <= `IRQ_RESET;
      irq_mask <= `IRQ_RESET;
      en_prev <= 5'h00;
      mem_pend <= 1'b0;
      wb_dat_o <= `WORD_RESET;
      wb_ack_o <= 1'b0;
      irq <= 1'b0;
      extracted_bit_out <= 1'b0;
      zero_flag <= 1'b0;
      extract_err <= 1'b0;
      insert_err <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      operand_a <= next_operand_a;
      operand_b <= next_operand_b;
      bit_index <= next_bit_index;
      logic_res <= next_logic_res;
      insert_dest <= next_insert_dest;
      source_base <= next_source_base;
      source_cnt <= next_source_cnt;
      x_base <= next_x_base;
      y_base <= next_y_base;
      table_length <= next_table_length;
      dest_base <= next_dest_base;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      en_prev <= next_en_prev;
      mem_pend <= next_mem_pend;
      wb_dat_o <= next_wb_dat_o;
      wb_ack_o <= next_wb_ack_o;
      irq <= next_irq;
      extracted_bit_out <= next_extracted_bit_out;
      zero_flag <= next_zero_flag;
      extract_err <= next_extract_err;
      insert_err <= next_insert_err;
    end
  end
endmodule

// ===== tb/plc_bit_logic_properties.sv
// port-level checker for the bit logic and interpolation unit
// assumes it is bound into plc_bit_logic_interp_unit, single clock, sync reset
`timescale 1ns/1ns
module plc_bit_logic_checker (
  input wire logic                         clk,               // clock
  input wire logic                         rst,               // reset
  input wire logic                         wb_stb_i,          // strobe
  input wire logic                         wb_cyc_i,          // cycle
  input wire logic                         wb_we_i,           // write
  input wire plc_bit_logic_pkg::bus_addr_t wb_adr_i,          // address
  input wire logic                         wb_ack_o,          // ack
  input wire logic                         extracted_bit_out, // extract bit
  input wire logic                         zero_flag,         // zero result
  input wire logic                         out_of_span_flag,  // interp miss
  input wire logic                         extract_err,       // extract error
  input wire logic                         insert_err         // insert error
);
  // ==========================================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");
  a_ack_has_request: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without a request");
  a_reg_one_cycle: assert property ($rose(wb_stb_i) && !wb_adr_i[12] |=> wb_ack_o)
    else $error("register access not answered next cycle");
  a_mem_read_two: assert property ($rose(wb_stb_i) && wb_adr_i[12] && !wb_we_i
    |=> !wb_ack_o)
    else $error("memory read answered too early");
  // flags move only one edge after a committed write, never on their own
  a_zero_cause: assert property ($changed(zero_flag) |-> $past(rst)
    || $past(wb_ack_o) && $past(wb_we_i))
    else $error("zero flag changed without a write");
  a_bit_cause: assert property ($changed(extracted_bit_out) |-> $past(rst)
    || $past(wb_ack_o) && $past(wb_we_i))
    else $error("extracted bit changed without a write");
  a_xerr_cause: assert property ($changed(extract_err) |-> $past(rst)
    || $past(wb_ack_o) && $past(wb_we_i))
    else $error("extract error changed without a write");
  a_ierr_cause: assert property ($changed(insert_err) |-> $past(rst)
    || $past(wb_ack_o) && $past(wb_we_i))
    else $error("insert error changed without a write");
  c_zero: cover property ($rose(zero_flag));
  c_span: cover property ($rose(out_of_span_flag));
  c_ins_err: cover property ($rose(insert_err));
endmodule

bind plc_bit_logic_interp_unit plc_bit_logic_checker u_checker (.clk, .rst, .wb_stb_i, .wb_cyc_i,
  .wb_we_i, .wb_adr_i, .wb_ack_o, .extracted_bit_out, .zero_flag, .out_of_span_flag,
  .extract_err, .insert_err);

// ===== tb/wb_host.sv
// classic wishbone master standing in for the ladder execution engine
// assumes a slave on the same clock; released write data shows inverted last value, adr, we and sel keep theirs
`timescale 1ns/1ns
module wb_host (
  input  wire logic                         clk,  // clock
  output      logic                         cyc,  // cycle
  output      logic                         stb,  // strobe
  output      logic                         we,   // write
  output      plc_bit_logic_pkg::bus_addr_t adr,  // address
  output      logic [3:0]                   sel,  // lanes
  output      plc_bit_logic_pkg::bus_word_t dat,  // write data
  input  wire plc_bit_logic_pkg::bus_word_t rdat, // read data
  input  wire logic                         ack   // acknowledge
);
  import plc_bit_logic_pkg::*;
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = 4'h0;
    dat = '0;
  end
  task automatic xfer(input logic w, input bus_addr_t a, input bus_word_t d,
                      output bus_word_t r, output logic ok);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= d;
    ok = 1'b0;
    r = '0;
    // long bound: memory requests stall while an interpolation runs
    for (int n = 0; n < 20000 && !ok; n++) begin
      @(posedge clk);
      ok = (ack === 1'b1);
      r = rdat;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    dat <= ~d;
  endtask
endmodule

// ===== tb/tb.sv
// self-checking bench for the bit logic and interpolation unit
// assumes wb_host as bus master and the bound checker
`timescale 1ns/1ns
`include "plc_bit_logic_consts.svh"
module tb;
  import plc_bit_logic_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc, stb, we, ack, irq, xb, zf, osf, xe, ie;
  logic [3:0] sel;
  bus_addr_t adr;
  bus_word_t dw, dr;
  int num_errors = 0;
  int check_count = 0;
  int ma [10] = '{0, 1, 2, 16, 17, 18, 32, 33, 34, 50};
  logic [15:0] mv [10] = '{16'h0032, 16'h0096, 16'h012c, 16'h0000, 16'h0064, 16'h00c8,
                           16'h0000, 16'hfc17, 16'h0bb8, 16'h1234};
  always #2 clk = ~clk;
  plc_bit_logic_interp_unit u_plc_bit_logic_interp_unit (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
    .wb_ack_o(ack), .irq(irq), .extracted_bit_out(xb), .zero_flag(zf),
    .out_of_span_flag(osf), .extract_err(xe), .insert_err(ie));
  wb_host host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(dw),
    .rdat(dr), .ack(ack));
  // ==========================================================
  // helpers
  task stop_test;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task acc(input logic w, input bus_addr_t a, input bus_word_t d, output bus_word_t r);
    logic ok;
    host.xfer(w, a, d, r, ok);
    if (!ok) begin
      chk(0, 1, "bus timeout");
      stop_test();
    end
    // land on the falling edge so flags are settled before they are compared
    @(negedge clk);
  endtask
  task wr(input bus_addr_t a, input bus_word_t d);
    bus_word_t r;
    acc(1'b1, a, d, r);
  endtask
  task rdc(input bus_addr_t a, input bus_word_t e, input string m);
    bus_word_t r;
    acc(1'b0, a, 32'h0, r);
    chk(r, e, m);
  endtask
  function automatic bus_addr_t mem(input int w);
    return 13'h1000 | 13'(w * 4);
  endfunction
  task run_interp(input bus_word_t c);
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_CTRL, c);
    for (int n = 0; n < 5000 && irq !== 1'b1; n++) @(negedge clk);
    chk(irq, 1, "interp done");
  endtask
  // ==========================================================
  // scenarios
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc(`OFS_CTRL, 32'h0, "ctrl reset");
    wr(13'h003c, 32'hffffffff);
    rdc(13'h003c, 32'h0, "unmapped");
    wr(`OFS_OPERAND_A, 32'h0000f0f0);
    wr(`OFS_OPERAND_B, 32'h0000ff00);
    wr(`OFS_CTRL, 32'h1 << `CTRL_XOR_EN);
    rdc(`OFS_LOGIC_RES, 32'h00000ff0, "xor");
    chk(zf, 0, "zero low");
    wr(`OFS_OPERAND_B, 32'h0000f0f0);
    rdc(`OFS_LOGIC_RES, 32'h0, "xor equal");
    chk(zf, 1, "zero high");
    wr(`OFS_OPERAND_B, 32'h0000ff00);
    wr(`OFS_CTRL, 32'h1 << `CTRL_EQUIV_EN);
    rdc(`OFS_LOGIC_RES, 32'h0000f00f, "equiv");
    wr(`OFS_OPERAND_A, 32'h0);
    wr(`OFS_OPERAND_B, 32'hffffffff);
    wr(`OFS_CTRL, (32'h1 << `CTRL_EQUIV_EN) | (32'h1 << `CTRL_WIDE));
    rdc(`OFS_LOGIC_RES, 32'h0, "equiv wide");
    chk(zf, 1, "zero wide");
    wr(`OFS_OPERAND_A, 32'h00000080);
    wr(`OFS_BIT_INDEX, 32'd7);
    wr(`OFS_CTRL, 32'h1 << `CTRL_EXTRACT_EN);
    chk(xb, 1, "extract");
    wr(`OFS_BIT_INDEX, 32'd16);
    chk(xe, 1, "extract err");
    chk(xb, 1, "extract held");
    wr(`OFS_CTRL, (32'h1 << `CTRL_EXTRACT_EN) | (32'h1 << `CTRL_WIDE));
    wr(`OFS_OPERAND_A, 32'h80000000);
    wr(`OFS_BIT_INDEX, 32'd31);
    chk({xe, xb}, 2'b01, "extract wide");
    wr(`OFS_CTRL, 32'h1 << `CTRL_WIDE);
    chk(xb, 1, "idle hold");
    wr(`OFS_CTRL, 32'h1 << `CTRL_IDLE_CLR);
    chk(xb, 0, "idle clear");
    wr(`OFS_INSERT_DEST, 32'h0000a5a5);
    wr(`OFS_BIT_INDEX, 32'd1);
    wr(`OFS_CTRL, (32'h1 << `CTRL_INSERT_EN) | (32'h1 << `CTRL_INSERT_BIT));
    rdc(`OFS_INSERT_DEST, 32'h0000a5a7, "insert");
    wr(`OFS_BIT_INDEX, 32'd16);
    wr(`OFS_INSERT_DEST, 32'h00000f00);
    rdc(`OFS_INSERT_DEST, 32'h00000f00, "insert refused");
    chk(ie, 1, "insert err");
    wr(`OFS_CTRL, 32'h0);
    rdc(`OFS_IRQ_STATUS, 32'h0000001c, "events");
    chk(irq, 0, "masked");
    wr(`OFS_IRQ_MASK, 32'h1 << `EV_INSERT_ERR);
    rdc(`OFS_IRQ_MASK, 32'h00000010, "mask");
    chk(irq, 1, "unmasked");
    wr(`OFS_IRQ_STATUS, 32'h0000001f);
    rdc(`OFS_IRQ_STATUS, 32'h0, "cleared");
    chk(irq, 0, "irq cleared");
    for (int i = 0; i < 10; i++) wr(mem(ma[i]), {16'h0, mv[i]});
    wr(`OFS_SOURCE_CNT, 32'd3);
    wr(`OFS_X_BASE, 32'd16);
    wr(`OFS_Y_BASE, 32'd32);
    wr(`OFS_TABLE_LEN, 32'd3);
    wr(`OFS_DEST_BASE, 32'd48);
    wr(`OFS_IRQ_MASK, 32'h1 << `EV_DONE);
    run_interp((32'h1 << `CTRL_INTERP_EN) | (32'h1 << `CTRL_PULSE));
    chk(osf, 1, "span miss");
    rdc(mem(48), 32'h0000fe0c, "interp trunc");
    rdc(mem(49), 32'h000003e7, "interp second");
    rdc(mem(50), 32'h00001234, "miss untouched");
    wr(`OFS_IRQ_STATUS, 32'h0000001f);
    wr(`OFS_SOURCE_BASE, 32'd49);
    wr(`OFS_SOURCE_CNT, 32'd1);
    wr(`OFS_DEST_BASE, 32'd51);
    run_interp(32'h1 | (32'h1 << `CTRL_PULSE) | (32'h1 << `CTRL_XY_SEL));
    rdc(mem(51), 32'h00000095, "inverse");
    chk(osf, 0, "span clear");
    wr(`OFS_IRQ_STATUS, 32'h0000001f);
    wr(`OFS_SOURCE_CNT, 32'd0);
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_CTRL, 32'h1 | (32'h1 << `CTRL_PULSE));
    repeat (200) @(negedge clk);
    rdc(`OFS_IRQ_STATUS, 32'h0, "bad count");
    stop_test();
  end
endmodule
